//--- hw/eki_pkg.sv
package eki_pkg;

  // Register offsets
  localparam logic [7:0] EKI_ADDR_IE_A  = 8'ha8;
  localparam logic [7:0] EKI_ADDR_IE_B  = 8'had;
  localparam logic [7:0] EKI_ADDR_LEV_B = 8'hae;
  localparam logic [7:0] EKI_ADDR_LEV_A = 8'hb8;
  localparam logic [7:0] EKI_ADDR_XCTRL = 8'hc0;
  localparam logic [7:0] EKI_ADDR_KPAT  = 8'hd5;
  localparam logic [7:0] EKI_ADDR_KCTRL = 8'hd6;
  localparam logic [7:0] EKI_ADDR_KSEL  = 8'hd7;
  localparam logic [7:0] EKI_ADDR_PWR   = 8'h87;
  localparam logic [7:0] EKI_ADDR_STAT  = 8'hf8;

  // Reset values
  localparam logic [7:0] EKI_RST_ZERO = 8'h00;
  localparam logic [7:0] EKI_KPAT_RST = 8'hff;

  // Field positions
  localparam int EKI_IE_GLOBAL  = 7;
  localparam int EKI_XC_TYPE    = 0;
  localparam int EKI_XC_FLAG    = 1;
  localparam int EKI_XC_EN      = 2;
  localparam int EKI_XC_POL     = 3;
  localparam int EKI_XC_STRIDE  = 4;
  localparam int EKI_B_SPI      = 0;
  localparam int EKI_B_KEY      = 5;
  localparam int EKI_B_TWSI     = 6;
  localparam int EKI_B_USB      = 7;
  localparam int EKI_KC_FLAG    = 0;
  localparam int EKI_KC_POL     = 1;
  localparam int EKI_PWR_IDLE   = 0;
  localparam int EKI_PWR_DOWN   = 1;
  localparam int EKI_ST_SVC_LO  = 0;
  localparam int EKI_ST_SVC_HI  = 1;
  localparam int EKI_ST_HALT    = 2;

  // Sources, index order is also the tie-break order within a level
  localparam int         EKI_NSRC      = 12;
  localparam int         EKI_NEXTRA    = 2;
  localparam logic [3:0] EKI_SRC_EXT_A = 4'h0;
  localparam logic [3:0] EKI_SRC_EXT_C = 4'h6;
  localparam logic [3:0] EKI_SRC_EXT_D = 4'h7;
  localparam logic [3:0] EKI_SRC_KEY   = 4'h9;
  localparam logic [11:0] EKI_OWN_MASK  = 12'h2c0;
  localparam logic [11:0] EKI_WAKE_MASK = 12'hac5;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eki_bus_t;

  typedef struct packed {
    logic       req;
    logic       high;
    logic [3:0] id;
  } eki_irq_t;

endpackage

//--- hw/eki_ctrl.sv
// Decided for this implementation: strobed register access.
module eki_ctrl
  import eki_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_reset,
  input  wire eki_bus_t            i_bus,
  output logic [7:0]               o_rdata,
  input  wire logic [EKI_NSRC-1:0] i_src_flag,
  input  wire logic [1:0]          i_extra_pin,
  input  wire logic [7:0]          i_key_port,
  input  wire logic                i_self_prog_halt,
  input  wire logic                i_irq_ack,
  input  wire logic                i_irq_return,
  output eki_irq_t                 o_irq,
  output logic                     o_idle,
  output logic                     o_power_down,
  output logic                     o_wake
);

  logic [7:0]          ie_a;
  logic [7:0]          ie_b;
  logic [7:0]          lev_a;
  logic [7:0]          lev_b;
  logic [7:0]          xctrl;
  logic [7:0]          kpat;
  logic                kpol;
  logic [7:0]          ksel;
  logic                key_flag;
  logic [1:0]          extra_flag;
  logic                svc_lo;
  logic                svc_hi;
  logic [7:0]          key_s1;
  logic [7:0]          key_s2;
  logic [1:0]          pin_s1;
  logic [1:0]          pin_s2;
  logic [1:0]          act_prev;
  logic [1:0]          act;
  logic [1:0]          edge_hit;
  logic                key_hit;
  logic [EKI_NSRC-1:0] flags;
  logic [EKI_NSRC-1:0] en;
  logic [EKI_NSRC-1:0] lvl;
  logic [EKI_NSRC-1:0] pend;
  logic                any_hi;
  logic                any_lo;
  logic [3:0]          hi_id;
  logic [3:0]          lo_id;
  eki_irq_t            next_irq;
  logic                wr_ie_a;
  logic                wr_xctrl;
  logic                wr_kctrl;
  logic                wr_pwr;
  logic                wake_pd;
  logic                wake_idle;

  assign wr_ie_a  = i_bus.wr && (i_bus.addr == EKI_ADDR_IE_A);
  assign wr_xctrl = i_bus.wr && (i_bus.addr == EKI_ADDR_XCTRL);
  assign wr_kctrl = i_bus.wr && (i_bus.addr == EKI_ADDR_KCTRL);
  assign wr_pwr   = i_bus.wr && (i_bus.addr == EKI_ADDR_PWR);

  // Plain configuration registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ie_a  <= EKI_RST_ZERO;
      ie_b  <= EKI_RST_ZERO;
      lev_a <= EKI_RST_ZERO;
      lev_b <= EKI_RST_ZERO;
      xctrl <= EKI_RST_ZERO;
      kpat  <= EKI_KPAT_RST;
      kpol  <= 1'b0;
      ksel  <= EKI_RST_ZERO;
    end else if (i_bus.wr) begin
      if (wr_ie_a)
        ie_a <= i_bus.wdata;
      if (i_bus.addr == EKI_ADDR_IE_B)
        ie_b <= i_bus.wdata;
      if (i_bus.addr == EKI_ADDR_LEV_A)
        lev_a <= i_bus.wdata;
      if (i_bus.addr == EKI_ADDR_LEV_B)
        lev_b <= i_bus.wdata;
      // Flag bits live in extra_flag; the copies here are never read
      if (wr_xctrl)
        xctrl <= i_bus.wdata;
      if (i_bus.addr == EKI_ADDR_KPAT)
        kpat <= i_bus.wdata;
      if (wr_kctrl)
        kpol <= i_bus.wdata[EKI_KC_POL];
      if (i_bus.addr == EKI_ADDR_KSEL)
        ksel <= i_bus.wdata;
    end
  end

  // Extra external inputs
  for (genvar k = 0; k < EKI_NEXTRA; k++) begin : g_extra
    localparam int B = k * EKI_XC_STRIDE;
    logic ack_me;

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        pin_s1[k] <= 1'b0;
        pin_s2[k] <= 1'b0;
      end else begin
        pin_s1[k] <= i_extra_pin[k];
        pin_s2[k] <= pin_s1[k];
      end
    end

    assign act[k] = xctrl[B + EKI_XC_POL] ? pin_s2[k] : ~pin_s2[k];
    assign edge_hit[k] = xctrl[B + EKI_XC_TYPE] && act[k] && !act_prev[k];
    assign ack_me = i_irq_ack && o_irq.req
                    && (o_irq.id == EKI_SRC_EXT_C + 4'(k));

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        act_prev[k]   <= 1'b0;
        extra_flag[k] <= 1'b0;
      end else begin
        act_prev[k] <= act[k];
        // level follows, edge clears on vector
        if (!xctrl[B + EKI_XC_TYPE])
          extra_flag[k] <= act[k];
        else if (edge_hit[k])
          extra_flag[k] <= 1'b1;
        else if (ack_me)
          extra_flag[k] <= 1'b0;
        else if (wr_xctrl)
          extra_flag[k] <= i_bus.wdata[B + EKI_XC_FLAG];
      end
    end
  end

  // Keypad port synchroniser
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      key_s1 <= EKI_RST_ZERO;
      key_s2 <= EKI_RST_ZERO;
    end else begin
      key_s1 <= i_key_port;
      key_s2 <= key_s1;
    end
  end

  assign key_hit = kpol ? ((key_s2 & ksel) == (kpat & ksel))
                        : ((key_s2 & ksel) != (kpat & ksel));

  // cleared only by software writing zero; set wins
  always_ff @(posedge i_clk) begin
    if (i_reset)
      key_flag <= 1'b0;
    else if (key_hit)
      key_flag <= 1'b1;
    else if (wr_kctrl && !i_bus.wdata[EKI_KC_FLAG])
      key_flag <= 1'b0;
  end

  // extra and keypad flags joined with the outside sources
  always_comb begin
    flags = i_src_flag & ~EKI_OWN_MASK;
    flags[EKI_SRC_EXT_C] = extra_flag[0];
    flags[EKI_SRC_EXT_D] = extra_flag[1];
    flags[EKI_SRC_KEY]   = key_flag;
  end

  always_comb begin
    en = {ie_b[EKI_B_USB], ie_b[EKI_B_TWSI], ie_b[EKI_B_KEY],
          ie_b[EKI_B_SPI], xctrl[EKI_XC_STRIDE + EKI_XC_EN],
          xctrl[EKI_XC_EN], ie_a[5:0]};
    // level register A maps straight onto sources 0 to 7
    // level register B bits 0, 5, 6, 7
    lvl = {lev_b[EKI_B_USB], lev_b[EKI_B_TWSI], lev_b[EKI_B_KEY],
           lev_b[EKI_B_SPI], lev_a};
  end

  assign pend = flags & en & {EKI_NSRC{ie_a[EKI_IE_GLOBAL]}};

  // Lowest index wins inside each level
  always_comb begin
    any_hi = 1'b0;
    any_lo = 1'b0;
    hi_id  = EKI_SRC_EXT_A;
    lo_id  = EKI_SRC_EXT_A;
    for (int i = EKI_NSRC - 1; i >= 0; i--) begin
      if (pend[i] && lvl[i]) begin
        any_hi = 1'b1;
        hi_id  = 4'(i);
      end
      if (pend[i] && !lvl[i]) begin
        any_lo = 1'b1;
        lo_id  = 4'(i);
      end
    end
  end

  // only a higher level than the running routine is offered
  // nothing offered while halted, flags keep the request queued
  always_comb begin
    next_irq.high = any_hi && !svc_hi;
    next_irq.id   = next_irq.high ? hi_id : lo_id;
    next_irq.req  = !i_self_prog_halt && !i_irq_ack
                    && (next_irq.high || (any_lo && !svc_lo && !svc_hi));
  end

  always_ff @(posedge i_clk) begin
    if (i_reset)
      o_irq <= '0;
    else
      o_irq <= next_irq;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      svc_lo <= 1'b0;
      svc_hi <= 1'b0;
    end else if (i_irq_ack && o_irq.req) begin
      if (o_irq.high)
        svc_hi <= 1'b1;
      else
        svc_lo <= 1'b1;
    end else if (i_irq_return) begin
      if (svc_hi)
        svc_hi <= 1'b0;
      else
        svc_lo <= 1'b0;
    end
  end

  // keypad is one of them, and wakes idle too
  assign wake_pd   = o_power_down && |(pend & EKI_WAKE_MASK);
  assign wake_idle = o_idle && |pend;

  // wake leaves the request standing for the CPU to vector
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_idle       <= 1'b0;
      o_power_down <= 1'b0;
      o_wake       <= 1'b0;
    end else begin
      o_wake <= wake_pd || wake_idle;
      if (wake_pd || wake_idle) begin
        o_idle       <= 1'b0;
        o_power_down <= 1'b0;
      end else if (wr_pwr) begin
        o_idle       <= i_bus.wdata[EKI_PWR_IDLE];
        o_power_down <= i_bus.wdata[EKI_PWR_DOWN];
      end
    end
  end

  // Read port, unmapped addresses read zero
  always_ff @(posedge i_clk) begin
    if (i_reset)
      o_rdata <= EKI_RST_ZERO;
    else if (i_bus.rd) begin
      unique case (i_bus.addr)
        EKI_ADDR_IE_A:  o_rdata <= ie_a;
        EKI_ADDR_IE_B:  o_rdata <= ie_b;
        EKI_ADDR_LEV_A: o_rdata <= lev_a;
        EKI_ADDR_LEV_B: o_rdata <= lev_b;
        EKI_ADDR_XCTRL: o_rdata <= {xctrl[7:6], extra_flag[1], xctrl[4:2],
                                    extra_flag[0], xctrl[0]};
        EKI_ADDR_KPAT:  o_rdata <= kpat;
        EKI_ADDR_KCTRL: o_rdata <= {6'h00, kpol, key_flag};
        EKI_ADDR_KSEL:  o_rdata <= ksel;
        EKI_ADDR_PWR:   o_rdata <= {6'h00, o_power_down, o_idle};
        EKI_ADDR_STAT:  o_rdata <= {5'h00, i_self_prog_halt, svc_hi, svc_lo};
        default:        o_rdata <= EKI_RST_ZERO;
      endcase
    end else
      o_rdata <= EKI_RST_ZERO;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_halt_end;
    i_self_prog_halt ##1 !i_self_prog_halt;
  endsequence

  sequence s_edge_c;
    xctrl[EKI_XC_TYPE] && !act_prev[0] && act[0];
  endsequence

  AST_KPAT_RESET: assert property (
    $fell(i_reset) |-> kpat == EKI_KPAT_RST)
    else $error("pattern not all ones after reset");

  AST_KEY_SET: assert property (key_hit |=> key_flag)
    else $error("keypad match did not set flag");

  AST_KEY_HOLD: assert property (key_flag && !wr_kctrl |=> key_flag)
    else $error("keypad flag cleared without software");

  AST_EDGE_SET: assert property (s_edge_c |=> extra_flag[0])
    else $error("edge on input c did not set flag");

  AST_LEVEL_FOLLOW: assert property (
    !xctrl[EKI_XC_TYPE] ##1 !xctrl[EKI_XC_TYPE]
      |-> extra_flag[0] == $past(act[0]))
    else $error("level flag does not follow pin");

  AST_GLOBAL_OFF: assert property (
    !ie_a[EKI_IE_GLOBAL] [*2] |-> !o_irq.req)
    else $error("request with global enable off");

  AST_HALT_HOLD: assert property (i_self_prog_halt |=> !o_irq.req)
    else $error("request offered during halt");

  AST_HALT_RESUME: assert property (
    s_halt_end ##0 (|pend && !svc_lo && !svc_hi && !i_irq_ack)
      |=> o_irq.req)
    else $error("queued request not served after halt");

  AST_NO_PREEMPT_HI: assert property (
    svc_hi && $past(svc_hi) |-> !o_irq.req)
    else $error("request during high level routine");

  AST_PREEMPT_LO: assert property (
    svc_lo && !svc_hi && o_irq.req |-> o_irq.high)
    else $error("low request offered over low routine");

  AST_PD_WAKE: assert property (
    o_power_down && |(pend & EKI_WAKE_MASK) |=> !o_power_down && o_wake)
    else $error("enabled wake source did not wake");

endmodule

//--- verif/eki_pin_model.sv
module eki_pin_model (
  input  wire logic       i_clk,
  output logic      [1:0] o_extra_pin,
  output logic      [7:0] o_key_port
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_extra_pin = 2'h0;
    // Keypad lines rest high on their pull-ups
    o_key_port = 8'hff;
  end

  // level held through halt
  // A pin only moves when the bench asks, so a request outlives a halt
  task automatic set_pin(input int idx, input logic v);
    @(posedge i_clk);
    o_extra_pin[idx] <= v;
  endtask

  // A pressed key pulls its line low
  task automatic press(input logic [7:0] keys);
    @(posedge i_clk);
    o_key_port <= ~keys;
  endtask
endmodule

//--- verif/testbench.sv
module testbench
  import eki_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_clk;
  logic        i_reset;
  eki_bus_t    bus;
  logic [7:0]  rdata;
  logic [11:0] src;
  logic [1:0]  pin;
  logic [7:0]  key;
  logic        halt;
  logic        ack;
  logic        ret;
  eki_irq_t    irq;
  logic        idle;
  logic        pd;
  logic        wake;
  logic        got;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;

  eki_ctrl dut (
    .i_clk            (i_clk),
    .i_reset          (i_reset),
    .i_bus            (bus),
    .o_rdata          (rdata),
    .i_src_flag       (src),
    .i_extra_pin      (pin),
    .i_key_port       (key),
    .i_self_prog_halt (halt),
    .i_irq_ack        (ack),
    .i_irq_return     (ret),
    .o_irq            (irq),
    .o_idle           (idle),
    .o_power_down     (pd),
    .o_wake           (wake)
  );

  eki_pin_model pm (
    .i_clk       (i_clk),
    .o_extra_pin (pin),
    .o_key_port  (key)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Well above the few hundred cycles the sequence needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk_irq(input logic h, input logic [3:0] id);
    check({2'h0, irq}, {2'h0, 1'b1, h, id});
  endtask

  task automatic chk_idle();
    check({7'h0, irq.req}, 8'h00);
  endtask

  task automatic pulse_ack();
    @(posedge i_clk);
    ack <= 1'b1;
    @(posedge i_clk);
    ack <= 1'b0;
  endtask

  task automatic pulse_ret();
    @(posedge i_clk);
    ret <= 1'b1;
    @(posedge i_clk);
    ret <= 1'b0;
  endtask

  task automatic wait_wake();
    got = 1'b0;
    repeat (12) begin
      @(posedge i_clk);
      #1;
      if (wake === 1'b1) got = 1'b1;
    end
  endtask

  initial begin
    i_reset = 1'b1;
    bus = '0;
    src = 12'h000;
    halt = 1'b0;
    ack = 1'b0;
    ret = 1'b0;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    rdchk(EKI_ADDR_KPAT, EKI_KPAT_RST);
    // Pins rest low, so both low-active level flags stand from reset
    rdchk(EKI_ADDR_XCTRL, 8'h22);
    rdchk(8'h01, 8'h00);
    wr(EKI_ADDR_LEV_A, 8'h48);
    rdchk(EKI_ADDR_LEV_A, 8'h48);
    wr(EKI_ADDR_LEV_B, 8'he1);
    rdchk(EKI_ADDR_LEV_B, 8'he1);
    wr(EKI_ADDR_LEV_B, 8'h00);
    // Timer A low, then halt, then high timer B over it
    src <= 12'h002;
    wr(EKI_ADDR_IE_A, 8'h02);
    gap(3);
    chk_idle();
    halt <= 1'b1;
    wr(EKI_ADDR_IE_A, 8'h82);
    gap(3);
    chk_idle();
    rdchk(EKI_ADDR_STAT, 8'h04);
    halt <= 1'b0;
    gap(3);
    chk_irq(1'b0, 4'h1);
    pulse_ack();
    gap(3);
    chk_idle();
    src <= 12'h00a;
    wr(EKI_ADDR_IE_A, 8'h8a);
    gap(3);
    chk_irq(1'b1, 4'h3);
    pulse_ack();
    gap(3);
    chk_idle();
    pulse_ret();
    gap(3);
    chk_irq(1'b1, 4'h3);
    pulse_ack();
    src <= 12'h000;
    pulse_ret();
    pulse_ret();
    wr(EKI_ADDR_IE_A, 8'h80);
    // Extra C: rising edge, enable off then on
    wr(EKI_ADDR_XCTRL, 8'h09);
    // Level mode left the flag up; clear it now that edge mode holds
    wr(EKI_ADDR_XCTRL, 8'h09);
    pm.set_pin(0, 1'b1);
    gap(5);
    rdchk(EKI_ADDR_XCTRL, 8'h2b);
    chk_idle();
    wr(EKI_ADDR_XCTRL, 8'h0f);
    gap(2);
    chk_irq(1'b1, EKI_SRC_EXT_C);
    pulse_ack();
    gap(2);
    chk_idle();
    rdchk(EKI_ADDR_XCTRL, 8'h2d);
    pulse_ret();
    pm.set_pin(0, 1'b0);
    gap(5);
    rdchk(EKI_ADDR_XCTRL, 8'h2d);
    // Extra D: level mode, low then high active
    wr(EKI_ADDR_XCTRL, 8'h49);
    gap(3);
    rdchk(EKI_ADDR_XCTRL, 8'h69);
    chk_irq(1'b0, EKI_SRC_EXT_D);
    pm.set_pin(1, 1'b1);
    gap(5);
    rdchk(EKI_ADDR_XCTRL, 8'h49);
    chk_idle();
    wr(EKI_ADDR_XCTRL, 8'hc9);
    gap(3);
    rdchk(EKI_ADDR_XCTRL, 8'he9);
    wr(EKI_ADDR_XCTRL, 8'h09);
    // Keypad: all-ones pattern, not-equal, line 0 selected
    wr(EKI_ADDR_IE_B, 8'h20);
    wr(EKI_ADDR_KSEL, 8'h01);
    wr(EKI_ADDR_KCTRL, 8'h00);
    pm.press(8'h02);
    gap(5);
    rdchk(EKI_ADDR_KCTRL, 8'h00);
    pm.press(8'h01);
    gap(5);
    rdchk(EKI_ADDR_KCTRL, 8'h01);
    chk_irq(1'b0, EKI_SRC_KEY);
    pm.press(8'h00);
    gap(5);
    rdchk(EKI_ADDR_KCTRL, 8'h01);
    wr(EKI_ADDR_IE_A, 8'h00);
    gap(3);
    chk_idle();
    wr(EKI_ADDR_KCTRL, 8'h00);
    rdchk(EKI_ADDR_KCTRL, 8'h00);
    wr(EKI_ADDR_KPAT, 8'hfe);
    wr(EKI_ADDR_KCTRL, 8'h02);
    // The pattern change matched before the polarity did; clear that
    wr(EKI_ADDR_KCTRL, 8'h02);
    gap(5);
    rdchk(EKI_ADDR_KCTRL, 8'h02);
    pm.press(8'h01);
    gap(5);
    rdchk(EKI_ADDR_KCTRL, 8'h03);
    pm.press(8'h00);
    wr(EKI_ADDR_KPAT, 8'hff);
    wr(EKI_ADDR_KCTRL, 8'h00);
    // Equal match on the way back set the flag again
    wr(EKI_ADDR_KCTRL, 8'h00);
    // Wake from power-down, then from idle, by a key
    wr(EKI_ADDR_IE_A, 8'h80);
    wr(EKI_ADDR_PWR, 8'h02);
    gap(1);
    check({7'h0, pd}, 8'h01);
    pm.press(8'h01);
    wait_wake();
    check({7'h0, got}, 8'h01);
    check({6'h0, pd, idle}, 8'h00);
    pm.press(8'h00);
    // Let the release pass the synchroniser before clearing
    gap(3);
    wr(EKI_ADDR_KCTRL, 8'h00);
    wr(EKI_ADDR_PWR, 8'h01);
    gap(1);
    check({7'h0, idle}, 8'h01);
    pm.press(8'h01);
    wait_wake();
    check({7'h0, got}, 8'h01);
    // Outside sources: own bits ignored, then level and index order
    pm.press(8'h00);
    gap(3);
    wr(EKI_ADDR_KCTRL, 8'h00);
    wr(EKI_ADDR_XCTRL, 8'h4d);
    wr(EKI_ADDR_IE_B, 8'he1);
    src <= 12'h2c0;
    gap(3);
    chk_idle();
    wr(EKI_ADDR_IE_A, 8'hbf);
    src <= 12'hfff;
    gap(3);
    chk_irq(1'b1, 4'h3);
    wr(EKI_ADDR_LEV_A, 8'h00);
    gap(2);
    chk_irq(1'b0, EKI_SRC_EXT_A);
    src <= 12'h500;
    gap(3);
    chk_irq(1'b0, 4'h8);
    // Spi and two-wire must not wake power-down, usb must
    wr(EKI_ADDR_PWR, 8'h02);
    gap(3);
    check({7'h0, pd}, 8'h01);
    src <= 12'hd00;
    wait_wake();
    check({7'h0, got}, 8'h01);
    check({6'h0, pd, idle}, 8'h00);
    finish_test();
  end
endmodule
